// ---- hdl/tbi_consts.vh ----
// Register offsets, field positions, reset values and source codes for the time base and irq block.
`ifndef TBI_CONSTS_VH
`define TBI_CONSTS_VH
`define TBI_ADDR_PSC        4'h0
`define TBI_ADDR_TBC        4'h1
`define TBI_ADDR_IRQ_EN     4'h2
`define TBI_ADDR_IRQ_FLAG   4'h3
`define TBI_ADDR_GLOBAL     4'h4
`define TBI_PSC_RESET       8'h00
`define TBI_TBC_RESET       8'h00
`define TBI_SRC_SYS         2'h0
`define TBI_SRC_SYS_DIV4    2'h1
`define TBI_SRC_LOW         2'h2
`define TBI_SRC_HIGH        2'h3
`define TBI_PSC0_LSB        0
`define TBI_PSC1_LSB        4
`define TBI_TB0_RUN_BIT     3
`define TBI_TB1_RUN_BIT     7
`define TBI_TB0_CODE_LSB    0
`define TBI_TB1_CODE_LSB    4
`define TBI_PERIOD_BASE_EXP 8
`define TBI_NUM_SRC         7
`define TBI_SRC_TB0         0
`define TBI_SRC_TB1         1
`define TBI_SRC_TWOWIRE     2
`define TBI_SRC_SERMOD      3
`define TBI_SRC_NVM         4
`define TBI_SRC_UART        5
`define TBI_SRC_LOWV        6
`define TBI_VEC_W           3
`define TBI_VEC_NONE        3'h7
`endif

// ---- hdl/tbi_timebase_irq.v ----
// Time base generators and peripheral interrupt flag latching with vector request.
//
// Function
// [R1] Prescaler 0 source: 00 system, 01 system/4, 10 low speed, 11 high speed.
// [R2] Prescaler select bits 3 and 2 read zero in the dual variant.
// [R3] Dual variant: prescaler 1 source in bits 5..4, same encoding.
// [R4] Time base 0 runs only while its enable is one; enable resets zero.
// [R5] Time base 0 period code 0..7 gives 2^8..2^15 prescaler 0 cycles.
// [R6] Dual variant: bit 7 enables time base 1.
// [R7] Time base 1 period code in bits 6..4 gives 2^8..2^15 cycles.
// [R8] Single variant: control bits 7..4 unimplemented and read zero.
// [R9] Time base flag sets on divider overflow, clears when serviced.
// [R10] Disabled time base holds its divider cleared, no overflow.
// [R11] Two-wire flag sets on byte done, address match or time-out.
// [R12] Two-wire vector needs global enable, source enable and flag.
// [R13] Servicing two-wire vector clears its flag and global enable.
// [R14] Serial module flag sets on byte done, address match or time-out.
// [R15] Serial module vector needs both enables; service clears flag and global.
// [R16] Nonvolatile write flag sets when a data-memory write finishes.
// [R17] Nonvolatile vector needs both enables; service clears flag and global.
// [R18] Any UART condition pulse sets the UART request flag.
// [R19] UART service clears its flag and global enable, not UART status.
// [R20] Low-voltage flag sets when the detector reports low supply.
// [R21] Low-voltage vector needs both enables; service clears flag and global.
// [R22] No vector request while the core's return stack is full.
`timescale 1ns/1ps
`include "tbi_consts.vh"

module tbi_timebase_irq #(
    parameter DUAL_TB     = 1,
    parameter HAS_SERMOD  = 0
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        low_speed_clock,
    input  wire        high_speed_clock,
    input  wire        twowire_byte_done,
    input  wire        twowire_addr_match,
    input  wire        twowire_timeout,
    input  wire        nvm_write_finished,
    input  wire        uart_tx_empty,
    input  wire        uart_tx_idle,
    input  wire        uart_rx_avail,
    input  wire        uart_rx_overrun,
    input  wire        uart_addr_detect,
    input  wire        uart_rx_wakeup,
    input  wire        low_voltage_detect,
    input  wire        stack_full,
    input  wire        vector_ack,
    output reg         vector_req,
    output reg  [2:0]  vector_id,
    output wire        global_irq_enable_out,
    output wire [6:0]  request_flags
);

    localparam NS = `TBI_NUM_SRC;

    reg  [7:0]    psc_sel;
    reg  [7:0]    timebase_control_single;
    reg  [NS-1:0] irq_en;
    reg  [NS-1:0] flag;
    reg           global_irq_enable;
    reg  [2:0]    low_sync;
    reg  [2:0]    high_sync;
    reg           low_state;
    reg           high_state;
    reg           low_prev;
    reg           high_prev;
    reg  [1:0]    div4;
    reg  [14:0]   tb0_div;
    reg  [14:0]   tb1_div;
    reg  [NS-1:0] next_flag;
    reg  [NS-1:0] events;
    reg  [NS-1:0] pending;
    reg  [2:0]    next_vec;
    reg           next_any;
    integer       i;

    wire low_edge  = low_state & ~low_prev;
    wire high_edge = high_state & ~high_prev;
    wire sys4_tick = (div4 == 2'h3);

    // Selects one prescaler tick from a two-bit source code.
    function src_tick;
        input [1:0] sel;
        input       t4;
        input       tl;
        input       th;
        begin
            case (sel)
                `TBI_SRC_SYS:      src_tick = 1'b1;
                `TBI_SRC_SYS_DIV4: src_tick = t4;
                `TBI_SRC_LOW:      src_tick = tl;
                default:           src_tick = th;
            endcase
        end
    endfunction

    // Overflow when the whole count equals two to the selected exponent minus one, so the next tick carries into it.
    function overflow_at;
        input [14:0] cnt;
        input [2:0]  code;
        reg   [15:0] lim;
        begin
            lim = 16'h0001 << (`TBI_PERIOD_BASE_EXP + code);
            overflow_at = ({1'b0, cnt} == (lim - 16'h0001));
        end
    endfunction

    wire [1:0] psc0_src  = psc_sel[`TBI_PSC0_LSB+1:`TBI_PSC0_LSB];
    wire [1:0] psc1_src  = psc_sel[`TBI_PSC1_LSB+1:`TBI_PSC1_LSB];
    wire       tb0_run   = timebase_control_single[`TBI_TB0_RUN_BIT];
    wire       tb1_run   = (DUAL_TB != 0) & timebase_control_single[`TBI_TB1_RUN_BIT];
    wire [2:0] tb0_code  = timebase_control_single[`TBI_TB0_CODE_LSB+2:`TBI_TB0_CODE_LSB];
    wire [2:0] tb1_code  = timebase_control_single[`TBI_TB1_CODE_LSB+2:`TBI_TB1_CODE_LSB];
    wire       psc0_tick = src_tick(psc0_src, sys4_tick, low_edge, high_edge); // [R1]
    wire       psc1_tick = src_tick(psc1_src, sys4_tick, low_edge, high_edge); // [R3]
    wire       tb0_ovf   = tb0_run & psc0_tick & overflow_at(tb0_div, tb0_code); // [R5]
    wire       tb1_ovf   = tb1_run & psc1_tick & overflow_at(tb1_div, tb1_code); // [R7]

    // Slow clocks are sampled; each counts once the second and third stages agree.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_sync   <= 3'h0;
            high_sync  <= 3'h0;
            low_state  <= 1'b0;
            high_state <= 1'b0;
            low_prev   <= 1'b0;
            high_prev  <= 1'b0;
            div4       <= 2'h0;
        end else begin
            low_sync  <= {low_sync[1:0], low_speed_clock};
            high_sync <= {high_sync[1:0], high_speed_clock};
            if (low_sync[1] == low_sync[2]) begin
                low_state <= low_sync[2];
            end
            if (high_sync[1] == high_sync[2]) begin
                high_state <= high_sync[2];
            end
            low_prev  <= low_state;
            high_prev <= high_state;
            div4      <= div4 + 2'h1;
        end
    end

    // Dividers restart from zero after each overflow and whenever disabled.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb0_div <= 15'h0000;
            tb1_div <= 15'h0000;
        end else begin
            if (!tb0_run || tb0_ovf) begin
                tb0_div <= 15'h0000; // [R4] [R10]
            end else if (psc0_tick) begin
                tb0_div <= tb0_div + 15'h0001;
            end
            if (!tb1_run || tb1_ovf) begin
                tb1_div <= 15'h0000; // [R6] [R10]
            end else if (psc1_tick) begin
                tb1_div <= tb1_div + 15'h0001;
            end
        end
    end

    // Event sources; the UART status flags live in the UART and are never touched here.
    always @* begin
        events = {NS{1'b0}};
        events[`TBI_SRC_TB0] = tb0_ovf; // [R9]
        events[`TBI_SRC_TB1] = tb1_ovf; // [R9]
        events[`TBI_SRC_TWOWIRE] = (HAS_SERMOD == 0) &
            (twowire_byte_done | twowire_addr_match | twowire_timeout); // [R11]
        events[`TBI_SRC_SERMOD] = (HAS_SERMOD != 0) &
            (twowire_byte_done | twowire_addr_match | twowire_timeout); // [R14]
        events[`TBI_SRC_NVM] = nvm_write_finished; // [R16]
        events[`TBI_SRC_UART] = uart_tx_empty | uart_tx_idle | uart_rx_avail |
            uart_rx_overrun | uart_addr_detect | uart_rx_wakeup; // [R18]
        events[`TBI_SRC_LOWV] = low_voltage_detect; // [R20]
    end

    // Lowest numbered pending source wins; a stack-full core sees no request.
    always @* begin
        pending  = flag & irq_en & {NS{global_irq_enable}}; // [R12] [R15] [R17] [R21]
        next_vec = `TBI_VEC_NONE;
        next_any = 1'b0;
        for (i = NS - 1; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                next_vec = i[2:0];
                next_any = 1'b1;
            end
        end
        next_any = next_any & ~stack_full; // [R22]
    end

    // Event set wins over a software or service clear in the same cycle.
    always @* begin
        next_flag = flag;
        if (reg_wr && reg_addr == `TBI_ADDR_IRQ_FLAG) begin
            next_flag = reg_wdata[NS-1:0];
        end
        if (vector_req && vector_ack) begin
            next_flag[vector_id] = 1'b0; // [R9] [R13] [R15] [R17] [R19] [R21]
        end
        next_flag = next_flag | events;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            psc_sel           <= `TBI_PSC_RESET;
            timebase_control_single               <= `TBI_TBC_RESET;
            irq_en            <= {NS{1'b0}};
            flag              <= {NS{1'b0}};
            global_irq_enable <= 1'b0;
            vector_req        <= 1'b0;
            vector_id         <= `TBI_VEC_NONE;
            reg_rdata         <= 8'h00;
        end else begin
            flag <= next_flag;
            if (reg_wr) begin
                case (reg_addr)
                    `TBI_ADDR_PSC: begin
                        psc_sel <= reg_wdata & ((DUAL_TB != 0) ? 8'h33 : 8'h03); // [R2]
                    end
                    `TBI_ADDR_TBC: begin
                        timebase_control_single <= reg_wdata & ((DUAL_TB != 0) ? 8'hff : 8'h0f); // [R8]
                    end
                    `TBI_ADDR_IRQ_EN: begin
                        irq_en <= reg_wdata[NS-1:0];
                    end
                    `TBI_ADDR_GLOBAL: begin
                        global_irq_enable <= reg_wdata[0];
                    end
                    default: begin
                    end
                endcase
            end
            // Servicing drops the global enable so nesting needs software consent.
            if (vector_req && vector_ack) begin
                global_irq_enable <= 1'b0; // [R13] [R15] [R17] [R19] [R21]
                vector_req        <= 1'b0;
            end else begin
                vector_req <= next_any; // [R12] [R22]
                vector_id  <= next_vec;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `TBI_ADDR_PSC:      reg_rdata <= psc_sel;
                    `TBI_ADDR_TBC:      reg_rdata <= timebase_control_single;
                    `TBI_ADDR_IRQ_EN:   reg_rdata <= {1'b0, irq_en};
                    `TBI_ADDR_IRQ_FLAG: reg_rdata <= {1'b0, flag};
                    `TBI_ADDR_GLOBAL:   reg_rdata <= {7'h00, global_irq_enable};
                    default:            reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    assign global_irq_enable_out = global_irq_enable;
    assign request_flags         = flag;

endmodule

// ---- verif/tbi_timebase_irq_assertions.sv ----
// Concurrent checks on the ports of the time base and irq block.
`timescale 1ns/1ps
`include "tbi_consts.vh"
module tbi_chk (
    input wire       clk,
    input wire       rst_b,
    input wire [3:0] reg_addr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       twowire_byte_done,
    input wire       twowire_addr_match,
    input wire       twowire_timeout,
    input wire       nvm_write_finished,
    input wire       uart_tx_empty,
    input wire       uart_tx_idle,
    input wire       uart_rx_avail,
    input wire       uart_rx_overrun,
    input wire       uart_addr_detect,
    input wire       uart_rx_wakeup,
    input wire       low_voltage_detect,
    input wire       stack_full,
    input wire       vector_ack,
    input wire       vector_req,
    input wire [2:0] vector_id,
    input wire       global_irq_enable_out,
    input wire [6:0] request_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_psc_gap_zero: assert property ($past(reg_rd) && $past(reg_addr) == `TBI_ADDR_PSC
        |-> (reg_rdata & 8'hcc) == 8'h00) else $error("prescaler gap bits not zero");
    a_req_gated: assert property ($rose(vector_req)
        |-> $past(global_irq_enable_out) && !$past(stack_full)) else $error("ungated request");
    a_stack_block: assert property (stack_full |=> !vector_req)
        else $error("request while stack full");
    a_ack_clear: assert property (vector_req && vector_ack
        |=> !vector_req && !global_irq_enable_out) else $error("service did not clear");
    a_nvm_clear: assert property (vector_req && vector_ack && vector_id == `TBI_SRC_NVM
        && !nvm_write_finished |=> !request_flags[4]) else $error("nvm flag kept");
    a_uart_set: assert property (uart_tx_empty || uart_tx_idle || uart_rx_avail
        || uart_rx_overrun || uart_addr_detect || uart_rx_wakeup |=> request_flags[5])
        else $error("uart flag not set");
    a_lowv_set: assert property (low_voltage_detect |=> request_flags[6])
        else $error("low voltage flag not set");
    a_twowire_set: assert property (twowire_byte_done || twowire_addr_match
        || twowire_timeout |=> request_flags[2]) else $error("two-wire flag not set");
    a_nvm_set: assert property (nvm_write_finished |=> request_flags[4])
        else $error("nvm flag not set");
    c_service: cover property (vector_req && vector_ack);
    c_stack: cover property (stack_full && request_flags != 7'h00);
    c_tb_flag: cover property ($rose(request_flags[0]));
endmodule
bind tbi_timebase_irq tbi_chk u_chk (.*);

// ---- verif/tbi_core_model.sv ----
// Core-side model: takes a vector after a set delay, refuses while its stack is full.
`timescale 1ns/1ps
module tbi_core_model (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       vector_req,
    input  wire [1:0] delay,
    input  wire       hold_full,
    output logic      vector_ack,
    output logic      stack_full
);
    logic [1:0] cnt;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_ack <= 1'b0;
            stack_full <= 1'b0;
            cnt        <= 2'h0;
        end else begin
            stack_full <= hold_full;
            vector_ack <= 1'b0;
            // A full stack means the request is simply not taken.
            if (vector_req && !vector_ack && !stack_full) begin
                cnt <= cnt + 2'h1;
                if (cnt == delay) begin
                    vector_ack <= 1'b1;
                    cnt        <= 2'h0;
                end
            end
        end
    end
endmodule

// ---- verif/tbi_timebase_irq_test.sv ----
// Self-checking bench for the time base and irq block.
`timescale 1ns/1ps
`include "tbi_consts.vh"
module tbi_timebase_irq_test;
    logic        clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, hold = 1'h0;
    logic [3:0]  a = 4'h0;
    logic [7:0]  wd = 8'h00, d, v;
    logic [10:0] ev = 11'h000;
    logic [1:0]  dly = 2'h0;
    logic        req, ack, ge, sf;
    logic [2:0]  vid;
    logic [6:0]  fl;
    logic [7:0]  rdat;
    logic [31:0] seed = 32'h00013434;
    integer      err_count = 0, samples_checked = 0, cyc = 0, t1, k;
    logic [7:0]  tt [5] = '{8'h08, 8'h09, 8'h08, 8'h80, 8'h90};
    logic [7:0]  pp [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h10};
    integer      bb [5] = '{0, 0, 0, 1, 1};
    integer      per [5] = '{256, 512, 1024, 256, 2048};
    tbi_timebase_irq dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(a), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .low_speed_clock(cyc[3]),
        .high_speed_clock(cyc[1]), .twowire_byte_done(ev[0]), .twowire_addr_match(ev[1]),
        .twowire_timeout(ev[2]), .nvm_write_finished(ev[3]), .uart_tx_empty(ev[4]),
        .uart_tx_idle(ev[5]), .uart_rx_avail(ev[6]), .uart_rx_overrun(ev[7]),
        .uart_addr_detect(ev[8]), .uart_rx_wakeup(ev[9]), .low_voltage_detect(ev[10]),
        .stack_full(sf), .vector_ack(ack), .vector_req(req), .vector_id(vid),
        .global_irq_enable_out(ge), .request_flags(fl));
    tbi_core_model core_u (.clk(clk), .rst_b(rst_b), .vector_req(req), .delay(dly),
        .hold_full(hold), .vector_ack(ack), .stack_full(sf));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    function automatic [31:0] rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    function automatic [2:0] src(input integer b);
        src = b < 3 ? 3'h2 : b == 3 ? 3'h4 : b == 10 ? 3'h6 : 3'h5;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic w(input logic [3:0] ad, input logic [7:0] dat);
        @(posedge clk);
        a <= ad; wd <= dat; wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rr(input logic [3:0] ad);
        @(posedge clk);
        a <= ad; rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdat;
    endtask
    task automatic ep(input integer b);
        @(posedge clk);
        ev[b] <= 1'h1;
        @(posedge clk);
        ev <= 11'h000;
    endtask
    task automatic wt(input logic lv);
        integer j;
        #1;
        for (j = 0; j < 40 && req !== lv; j++) @(posedge clk) #1;
    endtask
    task automatic wf(input integer b);
        integer j;
        // Step off the edge so a clear written on it is already visible.
        #1;
        for (j = 0; j < 3000 && fl[b] !== 1'b1; j++) @(posedge clk) #1;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        rr(`TBI_ADDR_PSC); chk(d, `TBI_PSC_RESET);
        rr(`TBI_ADDR_TBC); chk(d, `TBI_TBC_RESET);
        rr(4'hf); chk(d, 8'h00);
        for (k = 0; k < 6; k++) begin
            v = rnd();
            w(`TBI_ADDR_PSC, v); rr(`TBI_ADDR_PSC); chk(d, v & 8'h33);
            w(`TBI_ADDR_TBC, v); rr(`TBI_ADDR_TBC); chk(d, v);
        end
        $display("register test done");
        // Periods are timed between two flag rises, so start-up phase does not matter.
        for (k = 0; k < 5; k++) begin
            w(`TBI_ADDR_PSC, pp[k]); w(`TBI_ADDR_TBC, tt[k]); w(`TBI_ADDR_IRQ_FLAG, 8'h00);
            wf(bb[k]); t1 = cyc;
            w(`TBI_ADDR_IRQ_FLAG, 8'h00);
            wf(bb[k]); chk(cyc - t1, per[k]);
        end
        w(`TBI_ADDR_TBC, 8'h00); w(`TBI_ADDR_IRQ_FLAG, 8'h00);
        repeat (600) @(posedge clk);
        #1 chk(fl[1:0], 2'h0);
        $display("time base test done");
        w(`TBI_ADDR_IRQ_EN, 8'h7c);
        for (k = 0; k < 11; k++) begin
            dly <= 2'(rnd());
            w(`TBI_ADDR_GLOBAL, 8'h01); ep(k); wt(1'h1);
            chk(vid, src(k));
            wt(1'h0); chk({ge, fl}, 8'h00);
        end
        w(`TBI_ADDR_GLOBAL, 8'h00); ep(10);
        repeat (8) @(posedge clk);
        #1 chk(req, 1'h0);
        hold <= 1'h1;
        w(`TBI_ADDR_GLOBAL, 8'h01);
        repeat (8) @(posedge clk);
        #1 chk(req, 1'h0);
        hold <= 1'h0;
        wt(1'h1); chk(vid, 3'h6);
        wt(1'h0);
        $display("vector test done");
        end_sim;
    end
endmodule
